//--- rtl/nab_consts.svh
// Constants of the nibble ALU datapath: widths, reset values, encodings.
// Assumes inclusion by bare name from package and modules.
`ifndef NAB_CONSTS_SVH
`define NAB_CONSTS_SVH

// ==========================================================
// Widths
`define NAB_NIB_W        4
`define NAB_PTR_W        3
`define NAB_PAGE_W       7
`define NAB_ROM_W        10
`define NAB_ROM_ADDR_W   14

// ==========================================================
// Page limits
`define NAB_PAGE_MAX_SMALL 7'h3F
`define NAB_PAGE_MAX_LARGE 7'h5F

// ==========================================================
// Reset values
`define NAB_ACC_RST      4'h0
`define NAB_AUX_RST      4'h0
`define NAB_PTR_RST      3'h0
`define NAB_CARRY_RST    1'b0

// ==========================================================
// ROM word fields
`define NAB_ROM_UP_HI    9
`define NAB_ROM_UP_LO    8
`define NAB_ROM_AUX_HI   7
`define NAB_ROM_AUX_LO   4
`define NAB_ROM_ACC_HI   3
`define NAB_ROM_ACC_LO   0

`endif

//--- rtl/nab_pkg.sv
// Types of the nibble ALU datapath.
// Assumes nab_consts.svh on the include path.
`default_nettype none
`include "nab_consts.svh"

package nab_pkg;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    NAB_NOP                   = 4'h0,
    NAB_LOAD_IMMEDIATE_OP     = 4'h1,
    NAB_TABLE_READ_OP         = 4'h2,
    NAB_MEMORY_ADD_OP         = 4'h3,
    NAB_MEMORY_ADD_CARRY_OP   = 4'h4,
    NAB_ADD_IMMEDIATE_OP      = 4'h5,
    NAB_AND_OP                = 4'h6,
    NAB_OR_OP                 = 4'h7,
    NAB_CARRY_SET_OP          = 4'h8,
    NAB_CARRY_CLEAR_OP        = 4'h9,
    NAB_CARRY_TEST_SKIP_OP    = 4'hA,
    NAB_COMPLEMENT_OP         = 4'hB,
    NAB_ROTATE_RIGHT_CARRY_OP = 4'hC,
    NAB_BIT_SET_OP            = 4'hD,
    NAB_BIT_CLEAR_OP          = 4'hE,
    NAB_BIT_TEST_SKIP_OP      = 4'hF
  } nab_op_t;

  // ==========================================================
  // Instruction carrier
  typedef struct packed {
    nab_op_t                    op;
    logic [`NAB_NIB_W-1:0]      imm;
    logic [`NAB_PAGE_W-1:0]     page;
  } nab_instr_t;

  // ==========================================================
  // Table read sequencer, Gray coded
  typedef enum logic [1:0] {
    NAB_IDLE  = 2'b00,
    NAB_FETCH = 2'b01,
    NAB_LOAD  = 2'b11
  } nab_state_t;

endpackage : nab_pkg
`default_nettype wire

//--- rtl/nab_nibble_add.sv
// Four-bit adder with carry in and carry out.
// Pure combinational; used inside the datapath clock domain.
`default_nettype none
`include "nab_consts.svh"

module nab_nibble_add (
  // Operands
  input  wire logic [`NAB_NIB_W-1:0] a,
  input  wire logic [`NAB_NIB_W-1:0] b,
  input  wire logic                  cin,
  // Result
  output logic      [`NAB_NIB_W-1:0] sum,
  output logic                       cout
);
  import nab_pkg::*;

  logic [`NAB_NIB_W:0] full;

  assign full = {1'b0, a} + {1'b0, b} + {{`NAB_NIB_W{1'b0}}, cin};
  assign sum  = full[`NAB_NIB_W-1:0];
  assign cout = full[`NAB_NIB_W];

endmodule : nab_nibble_add
`default_nettype wire

//--- rtl/nab_bit_unit.sv
// Single-bit set, clear and test on one memory nibble.
// Pure combinational; index in range 0 to 3.
`default_nettype none
`include "nab_consts.svh"

module nab_bit_unit (
  // Operand
  input  wire logic [`NAB_NIB_W-1:0] nibble,
  input  wire logic [1:0]            index,
  // Results
  output logic      [`NAB_NIB_W-1:0] set_val,
  output logic      [`NAB_NIB_W-1:0] clear_val,
  output logic                       bit_val
);
  import nab_pkg::*;

  logic [`NAB_NIB_W-1:0] mask;

  assign mask      = 4'h1 << index;
  assign set_val   = nibble | mask;
  assign clear_val = nibble & ~mask;
  assign bit_val   = nibble[index];

endmodule : nab_bit_unit
`default_nettype wire

//--- rtl/nab_core.sv
// Execution datapath for load, table read, add, logic, carry and bit ops.
// Assumes ROM data valid the cycle after rom_req, memory nibble valid with instr.
//
// Overview of operation
// - Load immediate writes accumulator
// - Repeated loads after the first are skipped
// - Table read fills accumulator and auxiliary from ROM
// - Upper transfer flag loads pointer, clears bit two
// - Table read uses one stack level
// - Memory add, carry untouched
// - Add with carry updates carry flag
// - Add immediate keeps carry unchanged
// - Add immediate skips when no overflow
// - AND accumulator with memory nibble
// - OR accumulator with memory nibble
// - Carry set forces carry one
// - Carry clear forces carry zero
// - Carry test skips when carry zero
// - Complement inverts accumulator
// - Rotate right through carry
// - Bit set on memory nibble
// - Bit clear on memory nibble
// - Bit test skips when bit zero
// - Table page limited per variant
`default_nettype none
`include "nab_consts.svh"

module nab_core #(
  parameter logic LARGE_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Instruction stream
  input  wire logic                        instr_valid,
  input  wire nab_pkg::nab_instr_t         instr,
  output logic                             instr_ready,
  // Configuration
  input  wire logic                        table_upper_transfer_flag,
  // Data memory nibble
  input  wire logic [`NAB_NIB_W-1:0]       addressed_memory_nibble,
  output logic      [`NAB_NIB_W-1:0]       mem_wdata,
  output logic                             mem_we,
  // Program ROM
  output logic      [`NAB_ROM_ADDR_W-1:0]  rom_addr,
  output logic                             rom_req,
  input  wire logic [`NAB_ROM_W-1:0]       rom_data,
  // Return stack
  output logic                             return_stack_push,
  output logic                             return_stack_pop,
  output logic                             return_stack_held,
  // Register state
  output logic      [`NAB_NIB_W-1:0]       acc,
  output logic      [`NAB_NIB_W-1:0]       aux,
  output logic      [`NAB_PTR_W-1:0]       pointer,
  output logic                             carry_flag,
  // Sequencing
  output logic                             skip_next,
  output logic                             page_error
);
  import nab_pkg::*;

  // ==========================================================
  // Decode
  localparam logic [`NAB_PAGE_W-1:0] PAGE_MAX =
    LARGE_VARIANT ? `NAB_PAGE_MAX_LARGE : `NAB_PAGE_MAX_SMALL;

  nab_state_t            state;
  nab_state_t            next_state;
  logic                  last_was_load;
  logic                  take;
  logic                  discard;
  logic                  exec;
  logic                  page_ok;
  logic                  next_skip;

  logic [`NAB_NIB_W-1:0] add_b;
  logic                  add_cin;
  logic [`NAB_NIB_W-1:0] add_sum;
  logic                  add_cout;
  logic [`NAB_NIB_W-1:0] bit_set_val;
  logic [`NAB_NIB_W-1:0] bit_clear_val;
  logic                  bit_val;

  assign take    = instr_valid && instr_ready && (state == NAB_IDLE);
  assign discard = skip_next ||
                   (instr.op == NAB_LOAD_IMMEDIATE_OP && last_was_load);
  assign exec    = take && !discard;
  assign page_ok = (instr.page <= PAGE_MAX);

  // ==========================================================
  // Arithmetic and bit units
  always_comb begin
    add_b   = addressed_memory_nibble;
    add_cin = 1'b0;
    case (instr.op)
      NAB_MEMORY_ADD_CARRY_OP: begin
        add_cin = carry_flag;
      end
      NAB_ADD_IMMEDIATE_OP: begin
        add_b = instr.imm;
      end
      default: begin
        add_b   = addressed_memory_nibble;
        add_cin = 1'b0;
      end
    endcase
  end

  nab_nibble_add u_add (
    .a    (acc),
    .b    (add_b),
    .cin  (add_cin),
    .sum  (add_sum),
    .cout (add_cout)
  );

  nab_bit_unit u_bit (
    .nibble    (addressed_memory_nibble),
    .index     (instr.imm[1:0]),
    .set_val   (bit_set_val),
    .clear_val (bit_clear_val),
    .bit_val   (bit_val)
  );

  // ==========================================================
  // Skip decision
  always_comb begin
    next_skip = 1'b0;
    if (exec) begin
      case (instr.op)
        NAB_ADD_IMMEDIATE_OP:   next_skip = !add_cout;
        NAB_CARRY_TEST_SKIP_OP: next_skip = !carry_flag;
        NAB_BIT_TEST_SKIP_OP:   next_skip = !bit_val;
        default:                next_skip = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      skip_next <= 1'b0;
    end else if (take) begin
      skip_next <= next_skip;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_was_load <= 1'b0;
    end else if (take) begin
      last_was_load <= (instr.op == NAB_LOAD_IMMEDIATE_OP);
    end
  end

  // ==========================================================
  // Table read sequencer
  always_comb begin
    next_state = state;
    case (state)
      NAB_IDLE: begin
        if (exec && instr.op == NAB_TABLE_READ_OP && page_ok) begin
          next_state = NAB_FETCH;
        end
      end
      NAB_FETCH: next_state = NAB_LOAD;
      NAB_LOAD:  next_state = NAB_IDLE;
      default:   next_state = NAB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= NAB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_ready <= 1'b1;
    end else begin
      instr_ready <= (next_state == NAB_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rom_addr <= '0;
      rom_req  <= 1'b0;
    end else begin
      rom_req <= (state == NAB_IDLE) && (next_state == NAB_FETCH);
      if ((state == NAB_IDLE) && (next_state == NAB_FETCH)) begin
        rom_addr <= {instr.page, pointer, acc};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_error <= 1'b0;
    end else if (exec && instr.op == NAB_TABLE_READ_OP) begin
      page_error <= !page_ok;
    end
  end

  // ==========================================================
  // Return stack use
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      return_stack_push <= 1'b0;
      return_stack_pop  <= 1'b0;
      return_stack_held <= 1'b0;
    end else begin
      return_stack_push <= (state == NAB_IDLE) && (next_state == NAB_FETCH);
      return_stack_pop  <= (state == NAB_LOAD);
      return_stack_held <= (next_state != NAB_IDLE);
    end
  end

  // ==========================================================
  // Accumulator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc <= `NAB_ACC_RST;
    end else if (state == NAB_LOAD) begin
      acc <= rom_data[`NAB_ROM_ACC_HI:`NAB_ROM_ACC_LO];
    end else if (exec) begin
      case (instr.op)
        NAB_LOAD_IMMEDIATE_OP:     acc <= instr.imm;
        NAB_MEMORY_ADD_OP:         acc <= add_sum;
        NAB_MEMORY_ADD_CARRY_OP:   acc <= add_sum;
        NAB_ADD_IMMEDIATE_OP:      acc <= add_sum;
        NAB_AND_OP:                acc <= acc & addressed_memory_nibble;
        NAB_OR_OP:                 acc <= acc | addressed_memory_nibble;
        NAB_COMPLEMENT_OP:         acc <= ~acc;
        NAB_ROTATE_RIGHT_CARRY_OP: acc <= {carry_flag, acc[3:1]};
        default:                   acc <= acc;
      endcase
    end
  end

  // ==========================================================
  // Auxiliary and pointer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux     <= `NAB_AUX_RST;
      pointer <= `NAB_PTR_RST;
    end else if (state == NAB_LOAD) begin
      aux <= rom_data[`NAB_ROM_AUX_HI:`NAB_ROM_AUX_LO];
      if (table_upper_transfer_flag) begin
        pointer <= {1'b0, rom_data[`NAB_ROM_UP_HI:`NAB_ROM_UP_LO]};
      end
    end
  end

  // ==========================================================
  // Carry flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carry_flag <= `NAB_CARRY_RST;
    end else if (exec) begin
      case (instr.op)
        NAB_MEMORY_ADD_CARRY_OP:   carry_flag <= add_cout;
        NAB_CARRY_SET_OP:          carry_flag <= 1'b1;
        NAB_CARRY_CLEAR_OP:        carry_flag <= 1'b0;
        NAB_ROTATE_RIGHT_CARRY_OP: carry_flag <= acc[0];
        default:                   carry_flag <= carry_flag;
      endcase
    end
  end

  // ==========================================================
  // Memory write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_we    <= 1'b0;
      mem_wdata <= '0;
    end else begin
      mem_we <= exec && (instr.op == NAB_BIT_SET_OP || instr.op == NAB_BIT_CLEAR_OP);
      if (exec && instr.op == NAB_BIT_SET_OP) begin
        mem_wdata <= bit_set_val;
      end else if (exec && instr.op == NAB_BIT_CLEAR_OP) begin
        mem_wdata <= bit_clear_val;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_load_imm_acc: assert property (exec && instr.op == NAB_LOAD_IMMEDIATE_OP
    |=> acc == $past(instr.imm)) else $error("load immediate wrong");
  a_load_run_skip: assert property (take && last_was_load && instr.op == NAB_LOAD_IMMEDIATE_OP
    |=> $stable(acc)) else $error("repeated load took effect");
  a_table_fill: assert property (rom_req |=> ##1 (acc == $past(rom_data[3:0])
    && aux == $past(rom_data[7:4]) && return_stack_pop)) else $error("table fill wrong");
  a_table_upper: assert property (state == NAB_LOAD && table_upper_transfer_flag
    |=> pointer == {1'b0, $past(rom_data[9:8])}) else $error("pointer load wrong");
  a_stack_pair: assert property (return_stack_push |=> !return_stack_push ##1 return_stack_pop)
    else $error("stack not returned");
  a_adc_carry: assert property (exec && instr.op == NAB_MEMORY_ADD_CARRY_OP
    |=> {carry_flag, acc} == $past({1'b0, acc} + {1'b0, addressed_memory_nibble}
    + {4'h0, carry_flag})) else $error("add with carry wrong");
  a_addi_skip: assert property (exec && instr.op == NAB_ADD_IMMEDIATE_OP
    |=> $stable(carry_flag) && skip_next == !$past(add_cout)) else $error("add imm skip");
  a_carry_test: assert property (exec && instr.op == NAB_CARRY_TEST_SKIP_OP
    |=> skip_next == !carry_flag && $stable(carry_flag)) else $error("carry test wrong");
  a_rotate: assert property (exec && instr.op == NAB_ROTATE_RIGHT_CARRY_OP
    |=> {acc, carry_flag} == $past({carry_flag, acc})) else $error("rotate wrong");
  a_skip_inert: assert property (take && skip_next |=> $stable(acc) && $stable(carry_flag)
    && !mem_we && !rom_req) else $error("skipped op changed state");
  a_page_limit: assert property (rom_req |-> rom_addr[13:7] <= PAGE_MAX)
    else $error("page out of range");
  a_bit_clear: assert property (exec && instr.op == NAB_BIT_CLEAR_OP
    |=> mem_we && mem_wdata[$past(instr.imm[1:0])] == 1'b0) else $error("bit clear");

  c_table_read: cover property (rom_req ##2 return_stack_pop);
  c_load_run:   cover property (take && last_was_load && instr.op == NAB_LOAD_IMMEDIATE_OP);
  c_addi_skip:  cover property (exec && instr.op == NAB_ADD_IMMEDIATE_OP ##1 skip_next);
  c_bit_test:   cover property (exec && instr.op == NAB_BIT_TEST_SKIP_OP && !bit_val);

endmodule : nab_core
`default_nettype wire

//--- sim/nab_far_model.sv
// Far side model: program ROM, one data nibble, return stack depth.
// Assumes ROM read answered in the cycle after the request pulse.
`default_nettype none

module nab_far_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Program ROM
  input  wire logic [13:0] rom_addr,
  input  wire logic        rom_req,
  output logic      [9:0]  rom_data,
  // Data nibble
  input  wire logic        mem_we,
  input  wire logic [3:0]  mem_wdata,
  input  wire logic        preset,
  input  wire logic [3:0]  preset_val,
  output logic      [3:0]  addressed_memory_nibble,
  // Return stack
  input  wire logic        return_stack_push,
  input  wire logic        return_stack_pop,
  output logic      [2:0]  depth
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // ROM word for one cycle, inverted otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rom_data <= 10'h155;
    end else if (rom_req) begin
      rom_data <= {rom_addr[1:0], rom_addr[7:0]} ^ 10'h2C6;
    end else begin
      rom_data <= ~rom_data;
    end
  end

  // ==========================================================
  // Data nibble
  always_ff @(posedge ref_clk) begin
    if (preset) begin
      addressed_memory_nibble <= preset_val;
    end else if (mem_we) begin
      addressed_memory_nibble <= mem_wdata;
    end
  end

  // ==========================================================
  // Stack depth
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      depth <= 3'h0;
    end else begin
      depth <= depth + 3'(return_stack_push) - 3'(return_stack_pop);
    end
  end
endmodule : nab_far_model
`default_nettype wire

//--- sim/nab_core_bench.sv
// Self-checking bench of the nibble ALU datapath.
// Assumes nab_pkg and the far side model compiled first.
`default_nettype none

module nab_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import nab_pkg::*;

  // ==========================================================
  // Signals
  logic        ref_clk, rst, instr_valid, instr_ready, table_upper_transfer_flag;
  nab_instr_t  instr;
  logic [3:0]  addressed_memory_nibble, mem_wdata, acc, aux, preset_val;
  logic        mem_we, rom_req, preset, carry_flag, skip_next, page_error;
  logic        return_stack_push, return_stack_pop, return_stack_held;
  logic [13:0] rom_addr;
  logic [9:0]  rom_data;
  logic [2:0]  pointer, depth;
  int          error_cnt = 0;
  int          check_count = 0;

  nab_core #(.LARGE_VARIANT(1'b0)) dut (
    .ref_clk, .rst, .instr_valid, .instr, .instr_ready, .table_upper_transfer_flag,
    .addressed_memory_nibble, .mem_wdata, .mem_we, .rom_addr, .rom_req, .rom_data,
    .return_stack_push, .return_stack_pop, .return_stack_held, .acc, .aux,
    .pointer, .carry_flag, .skip_next, .page_error);

  nab_far_model far (
    .ref_clk, .rst, .rom_addr, .rom_req, .rom_data, .mem_we, .mem_wdata, .preset,
    .preset_val, .addressed_memory_nibble, .return_stack_push, .return_stack_pop, .depth);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic wait_ready;
    int n = 0;
    @(negedge ref_clk);
    while (instr_ready !== 1'b1) begin
      n++;
      if (n > 8) begin
        error_cnt++;
        complete_run();
      end
      @(negedge ref_clk);
    end
  endtask : wait_ready

  task automatic go(input nab_op_t op, input logic [3:0] imm, input logic [6:0] pg = 7'h00);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr <= '{op: op, imm: imm, page: pg};
    wait_ready();
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : go

  task automatic set_mem(input logic [3:0] v);
    @(posedge ref_clk);
    preset <= 1'b1;
    preset_val <= v;
    @(posedge ref_clk);
    preset <= 1'b0;
  endtask : set_mem

  // ==========================================================
  // Scenarios
  task automatic t_load;
    go(NAB_LOAD_IMMEDIATE_OP, 4'h5);
    chk("acc", acc, 4'h5);
    go(NAB_LOAD_IMMEDIATE_OP, 4'h9);
    go(NAB_LOAD_IMMEDIATE_OP, 4'h3);
    chk("acc", acc, 4'h5);
    go(NAB_NOP, 4'h0);
    go(NAB_LOAD_IMMEDIATE_OP, 4'hA);
    chk("acc", acc, 4'hA);
  endtask : t_load

  task automatic t_add;
    set_mem(4'h6);
    go(NAB_CARRY_CLEAR_OP, 4'h0);
    go(NAB_LOAD_IMMEDIATE_OP, 4'h7);
    go(NAB_MEMORY_ADD_OP, 4'h0);
    chk("acc", {carry_flag, acc}, 5'h0D);
    go(NAB_CARRY_SET_OP, 4'h0);
    go(NAB_MEMORY_ADD_OP, 4'h0);
    chk("acc", {carry_flag, acc}, 5'h13);
    go(NAB_MEMORY_ADD_CARRY_OP, 4'h0);
    chk("acc", {carry_flag, acc}, 5'h0A);
    go(NAB_MEMORY_ADD_CARRY_OP, 4'h0);
    chk("acc", {carry_flag, acc}, 5'h10);
  endtask : t_add

  task automatic t_addimm;
    go(NAB_NOP, 4'h0);
    go(NAB_LOAD_IMMEDIATE_OP, 4'h5);
    go(NAB_ADD_IMMEDIATE_OP, 4'h3);
    chk("acc", {carry_flag, acc}, 5'h18);
    chk("skip", skip_next, 1'b1);
    go(NAB_COMPLEMENT_OP, 4'h0);
    chk("acc", {skip_next, acc}, 5'h08);
    go(NAB_ADD_IMMEDIATE_OP, 4'h9);
    chk("acc", {carry_flag, acc}, 5'h11);
    chk("skip", skip_next, 1'b0);
    go(NAB_COMPLEMENT_OP, 4'h0);
    chk("acc", acc, 4'hE);
  endtask : t_addimm

  task automatic t_logic;
    set_mem(4'h3);
    go(NAB_AND_OP, 4'h0);
    chk("acc", acc, 4'h2);
    set_mem(4'h9);
    go(NAB_OR_OP, 4'h0);
    chk("acc", acc, 4'hB);
    chk("carry", carry_flag, 1'b1);
  endtask : t_logic

  task automatic t_rot_carry;
    go(NAB_ROTATE_RIGHT_CARRY_OP, 4'h0);
    chk("rot", {carry_flag, acc}, 5'h1D);
    go(NAB_CARRY_CLEAR_OP, 4'h0);
    chk("carry", carry_flag, 1'b0);
    go(NAB_ROTATE_RIGHT_CARRY_OP, 4'h0);
    chk("rot", {carry_flag, acc}, 5'h16);
    go(NAB_CARRY_CLEAR_OP, 4'h0);
    go(NAB_CARRY_TEST_SKIP_OP, 4'h0);
    chk("skip", {skip_next, carry_flag}, 2'b10);
    go(NAB_CARRY_SET_OP, 4'h0);
    chk("skip", {skip_next, carry_flag}, 2'b00);
    go(NAB_CARRY_SET_OP, 4'h0);
    chk("carry", {carry_flag, acc}, 5'h16);
    go(NAB_CARRY_TEST_SKIP_OP, 4'h0);
    chk("skip", {skip_next, carry_flag}, 2'b01);
  endtask : t_rot_carry

  task automatic t_bits;
    logic [3:0] m;
    for (int j = 0; j < 4; j++) begin
      m = 4'h1 << j;
      set_mem(4'h0);
      go(NAB_BIT_SET_OP, 4'(j));
      chk("we", mem_we, 1'b1);
      chk("wdata", mem_wdata, m);
      set_mem(4'hF);
      go(NAB_BIT_CLEAR_OP, 4'(j));
      chk("wdata", mem_wdata, m ^ 4'hF);
      set_mem(m);
      go(NAB_BIT_TEST_SKIP_OP, 4'(j));
      chk("skip", skip_next, 1'b0);
      go(NAB_BIT_TEST_SKIP_OP, 4'((j + 1) % 4));
      chk("skip", skip_next, 1'b1);
      go(NAB_NOP, 4'h0);
    end
    chk("carry", carry_flag, 1'b1);
  endtask : t_bits

  task automatic tread(input logic [6:0] pg, input logic up);
    logic [13:0] a;
    logic [9:0]  w;
    logic [2:0]  p;
    p = pointer;
    a = {pg, pointer, acc};
    w = {a[1:0], a[7:0]} ^ 10'h2C6;
    @(posedge ref_clk);
    table_upper_transfer_flag <= up;
    go(NAB_TABLE_READ_OP, 4'h0, pg);
    chk("rom_addr", rom_addr, a);
    @(posedge ref_clk);
    #1;
    chk("depth", {return_stack_held, depth}, 4'h9);
    wait_ready();
    @(posedge ref_clk);
    #1;
    chk("acc", acc, w[3:0]);
    chk("aux", aux, w[7:4]);
    chk("pointer", pointer, up ? {1'b0, w[9:8]} : p);
    chk("depth", {return_stack_held, depth}, 4'h0);
    chk("page_error", page_error, 1'b0);
  endtask : tread

  task automatic t_table;
    logic [3:0] a0;
    go(NAB_LOAD_IMMEDIATE_OP, 4'h3);
    tread(7'h05, 1'b0);
    tread(7'h3F, 1'b1);
    tread(7'h3F, 1'b0);
    a0 = acc;
    go(NAB_TABLE_READ_OP, 4'h0, 7'h40);
    wait_ready();
    @(posedge ref_clk);
    #1;
    chk("page_error", {page_error, acc}, {1'b1, a0});
  endtask : t_table

  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("reset", {aux, pointer, page_error, instr_ready, carry_flag, acc}, 14'h0020);
    chk("reset", {skip_next, rom_addr[12:0]}, 14'h0000);
    chk("rom_addr", rom_addr, 14'h0000);
  endtask : t_reset

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    table_upper_transfer_flag = 1'b0;
    preset = 1'b0;
    preset_val = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("reset", {instr_ready, carry_flag, acc}, 6'h20);
    t_load();
    t_add();
    t_addimm();
    t_logic();
    t_rot_carry();
    t_bits();
    t_table();
    t_reset();
    complete_run();
  end
endmodule : nab_core_bench
`default_nettype wire
